// [rtl/smif_pkg.sv]
// constants, register map and field layout of the supply monitor and interrupt flag bank
package smif_pkg;

	// ****************************************
	// register map (byte offsets, one word each)
	// ****************************************
	localparam int SMIF_NUM_REGS = 14;
	localparam int SMIF_R_SUPPLY = 0;
	localparam int SMIF_R_HALL_EDGE = 1;
	localparam int SMIF_R_EXT_EDGE = 2;
	localparam int SMIF_R_PRI_A = 3;
	localparam int SMIF_R_PRI_B = 4;
	localparam int SMIF_R_PRI_C = 5;
	localparam int SMIF_R_PRI_D = 6;
	localparam int SMIF_R_GRP_HALL = 7;
	localparam int SMIF_R_GRP_CAP_ADC = 8;
	localparam int SMIF_R_GRP_PWM = 9;
	localparam int SMIF_R_GRP_TM2 = 10;
	localparam int SMIF_R_GRP_TM0 = 11;
	localparam int SMIF_R_GRP_TM1 = 12;
	localparam int SMIF_R_GRP_TM3 = 13;
	localparam logic [7:0] SMIF_OFF_SUPPLY_MONITOR_CTRL = 8'h00;
	localparam logic [7:0] SMIF_OFF_HALL_EDGE_SELECT = 8'h04;
	localparam logic [7:0] SMIF_OFF_EXT_PIN_EDGE_SELECT = 8'h08;
	localparam logic [7:0] SMIF_OFF_PRIMARY_IRQ_CTRL_A = 8'h0C;
	localparam logic [7:0] SMIF_OFF_PRIMARY_IRQ_CTRL_B = 8'h10;
	localparam logic [7:0] SMIF_OFF_PRIMARY_IRQ_CTRL_C = 8'h14;
	localparam logic [7:0] SMIF_OFF_PRIMARY_IRQ_CTRL_D = 8'h18;
	localparam logic [7:0] SMIF_OFF_GROUPED_IRQ_HALL = 8'h1C;
	localparam logic [7:0] SMIF_OFF_GROUPED_IRQ_CAPTURE_ADC = 8'h20;
	localparam logic [7:0] SMIF_OFF_GROUPED_IRQ_PWM = 8'h24;
	localparam logic [7:0] SMIF_OFF_GROUPED_IRQ_TIMER2 = 8'h28;
	localparam logic [7:0] SMIF_OFF_GROUPED_IRQ_TIMER0 = 8'h2C;
	localparam logic [7:0] SMIF_OFF_GROUPED_IRQ_TIMER1 = 8'h30;
	localparam logic [7:0] SMIF_OFF_GROUPED_IRQ_TIMER3 = 8'h34;

	// ****************************************
	// reset value and writable bits per register
	// ****************************************
	localparam logic [7:0] SMIF_RST_REG = 8'h00;
	localparam logic [7:0] SMIF_IMPL_MASK [SMIF_NUM_REGS] = '{
		8'h17, 8'h7F, 8'h03, 8'h7F, 8'hFF, 8'hFF, 8'hDD,
		8'h77, 8'hFF, 8'hFF, 8'h33, 8'h33, 8'h33, 8'h33};

	// ****************************************
	// field positions
	// ****************************************
	localparam int SMIF_POS_LOW_FLAG = 5;
	localparam int SMIF_POS_MON_EN = 4;
	localparam int SMIF_POS_THRESH = 0;
	localparam int SMIF_THRESH_W = 3;
	localparam int SMIF_POS_GLOBAL_EN = 0;
	localparam int SMIF_POS_SUPPLY_IRQ_FLAG = 6;
	localparam int SMIF_POS_SUPPLY_IRQ_EN = 2;
	localparam int SMIF_POS_HALL_SEL = 6;
	localparam int SMIF_POS_EDGE_A = 0;
	localparam int SMIF_POS_EDGE_B = 2;
	localparam int SMIF_POS_EDGE_C = 4;
	localparam int SMIF_POS_EXT_EDGE = 0;

	typedef enum logic [1:0] {
		SMIF_EDGE_OFF = 2'h0,
		SMIF_EDGE_RISE = 2'h1,
		SMIF_EDGE_FALL = 2'h2,
		SMIF_EDGE_BOTH = 2'h3
	} smif_edge_type;

	// ****************************************
	// bus answers and timing
	// ****************************************
	localparam logic [1:0] SMIF_RESP_OKAY = 2'h0;
	localparam logic [1:0] SMIF_RESP_SLVERR = 2'h2;
	localparam int SMIF_CLK_PERIOD_NS = 50;
	localparam int SMIF_IRQ_DELAY_NS = 20000;
	localparam int SMIF_IRQ_DELAY_CYC = (SMIF_IRQ_DELAY_NS + SMIF_CLK_PERIOD_NS - 1)
		/ SMIF_CLK_PERIOD_NS;

endpackage

// [rtl/smif_pin_sync.sv]
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module smif_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] level
);
	logic [W-1:0] stage1_r;
	logic [W-1:0] stage2_r;
	logic [W-1:0] stage3_r;
	logic [W-1:0] level_r;

	// stage1 feeds stage2 only; the agreement test looks at stages 2 and 3
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
		end else if (ce) begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	for (genvar g = 0; g < W; g++) begin : gBit
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				level_r[g] <= 1'b0;
			end else if (ce && (stage2_r[g] == stage3_r[g])) begin
				level_r[g] <= stage3_r[g];
			end
		end
	end

	assign level = level_r;
endmodule

// [rtl/smif_top.sv]
// supply monitor control and interrupt enable / request flag bank, AXI4-Lite slave
// ****************************************
// ****************************************
`timescale 1ns/1ps
module smif_top
	import smif_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int IRQ_DELAY_CYC = SMIF_IRQ_DELAY_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic supplyBelowThreshold,
	input wire logic sleepMode,
	input wire logic idleMode,
	input wire logic [2:0] hallPin,
	input wire logic [2:0] hallCompOut,
	input wire logic filteredInputPin,
	input wire logic extIrqPin,
	input wire logic comp0Evt,
	input wire logic overcurrentEvt,
	input wire logic timeBaseEvt,
	input wire logic uartEvt,
	input wire logic captureMatchEvt,
	input wire logic captureOverflowEvt,
	input wire logic adcLimitEvt,
	input wire logic adcEndEvt,
	input wire logic pwmPeriodEvt,
	input wire logic [2:0] pwmDutyEvt,
	input wire logic [3:0] timerPeriodEvt,
	input wire logic [3:0] timerMatchEvt,
	output logic [2:0] thresholdSelect,
	output logic monitorPowerOn,
	output logic irqRequest,
	output logic wakeFromIdle
);
	// ****************************************
	// functions
	// ****************************************
	// returns {hit, index}; misaligned or unknown addresses miss
	function automatic logic [4:0] regDecode(input logic [ADDR_W-1:0] addr);
		logic [7:0] a;
		a = 8'(addr);
		if (ADDR_W > 8 && (addr >> 8) != '0) regDecode = 5'h00;
		else if (a == SMIF_OFF_SUPPLY_MONITOR_CTRL) regDecode = 5'h10;
		else if (a == SMIF_OFF_HALL_EDGE_SELECT) regDecode = 5'h11;
		else if (a == SMIF_OFF_EXT_PIN_EDGE_SELECT) regDecode = 5'h12;
		else if (a == SMIF_OFF_PRIMARY_IRQ_CTRL_A) regDecode = 5'h13;
		else if (a == SMIF_OFF_PRIMARY_IRQ_CTRL_B) regDecode = 5'h14;
		else if (a == SMIF_OFF_PRIMARY_IRQ_CTRL_C) regDecode = 5'h15;
		else if (a == SMIF_OFF_PRIMARY_IRQ_CTRL_D) regDecode = 5'h16;
		else if (a == SMIF_OFF_GROUPED_IRQ_HALL) regDecode = 5'h17;
		else if (a == SMIF_OFF_GROUPED_IRQ_CAPTURE_ADC) regDecode = 5'h18;
		else if (a == SMIF_OFF_GROUPED_IRQ_PWM) regDecode = 5'h19;
		else if (a == SMIF_OFF_GROUPED_IRQ_TIMER2) regDecode = 5'h1A;
		else if (a == SMIF_OFF_GROUPED_IRQ_TIMER0) regDecode = 5'h1B;
		else if (a == SMIF_OFF_GROUPED_IRQ_TIMER1) regDecode = 5'h1C;
		else if (a == SMIF_OFF_GROUPED_IRQ_TIMER3) regDecode = 5'h1D;
		else regDecode = 5'h00;
	endfunction

	function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
		edgeHit = 1'b0;
		case (smif_edge_type'(sel))
			SMIF_EDGE_RISE: edgeHit = cur & ~prev;
			SMIF_EDGE_FALL: edgeHit = ~cur & prev;
			SMIF_EDGE_BOTH: edgeHit = cur ^ prev;
			default: edgeHit = 1'b0;
		endcase
	endfunction

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] regs_r [SMIF_NUM_REGS];
	logic [7:0] setVec [SMIF_NUM_REGS];
	logic [8:0] pinLevel;
	logic [2:0] hallLevel;
	logic [2:0] hallPrev_r;
	logic extPrev_r;
	logic filtPrev_r;
	logic [2:0] hallSet;
	logic extSet;
	logic filtSet;
	logic monActive;
	logic lowFlag;
	logic [15:0] delayCnt_r;
	logic supplyIrqSet;
	logic [6:0] mfEvt;
	logic [3:0] timerIdx [4];
	logic irqRequest_r;
	logic wake_r;
	logic awHeld_r;
	logic wHeld_r;
	logic [ADDR_W-1:0] awAddr_r;
	logic [7:0] wData_r;
	logic wStrb0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic wrFire;
	logic [4:0] wrDec;
	logic [4:0] rdDec;
	logic [7:0] rdVal;

	// ****************************************
	// pin synchronisers
	// ****************************************
	smif_pin_sync #(.W(9)) uPinSync (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.pinIn({supplyBelowThreshold, extIrqPin, filteredInputPin, hallCompOut, hallPin}),
		.level(pinLevel)
	);

	// ****************************************
	// supply monitor
	// ****************************************
	assign monActive = regs_r[SMIF_R_SUPPLY][SMIF_POS_MON_EN] & ~sleepMode;
	assign monitorPowerOn = monActive;
	assign thresholdSelect = regs_r[SMIF_R_SUPPLY][SMIF_POS_THRESH +: SMIF_THRESH_W];
	// only the synchroniser stands between comparator and flag, so chatter passes through
	assign lowFlag = monActive & pinLevel[8];

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			delayCnt_r <= 16'h0000;
		end else if (ce) begin
			if (!lowFlag) begin
				delayCnt_r <= 16'h0000;
			end else if (delayCnt_r != 16'(IRQ_DELAY_CYC)) begin
				delayCnt_r <= delayCnt_r + 16'h0001;
			end
		end
	end

	// one set per low episode; the counter parks at its end value
	assign supplyIrqSet = lowFlag && (delayCnt_r == 16'(IRQ_DELAY_CYC - 1));

	// ****************************************
	// external edge detection
	// ****************************************
	// a change of the select bit can itself look like an edge on the hall lines
	assign hallLevel = regs_r[SMIF_R_HALL_EDGE][SMIF_POS_HALL_SEL] ? pinLevel[5:3]
		: pinLevel[2:0];

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hallPrev_r <= 3'h0;
			extPrev_r <= 1'b0;
			filtPrev_r <= 1'b0;
		end else if (ce) begin
			hallPrev_r <= hallLevel;
			extPrev_r <= pinLevel[7];
			filtPrev_r <= pinLevel[6];
		end
	end

	assign hallSet[0] = edgeHit(regs_r[SMIF_R_HALL_EDGE][SMIF_POS_EDGE_A +: 2],
		hallPrev_r[0], hallLevel[0]);
	assign hallSet[1] = edgeHit(regs_r[SMIF_R_HALL_EDGE][SMIF_POS_EDGE_B +: 2],
		hallPrev_r[1], hallLevel[1]);
	assign hallSet[2] = edgeHit(regs_r[SMIF_R_HALL_EDGE][SMIF_POS_EDGE_C +: 2],
		hallPrev_r[2], hallLevel[2]);
	assign extSet = edgeHit(regs_r[SMIF_R_EXT_EDGE][SMIF_POS_EXT_EDGE +: 2],
		extPrev_r, pinLevel[7]);
	assign filtSet = pinLevel[6] & ~filtPrev_r;

	// ****************************************
	// flag set vectors
	// ****************************************
	// grouped register index for each timer number
	assign timerIdx[0] = 4'(SMIF_R_GRP_TM0);
	assign timerIdx[1] = 4'(SMIF_R_GRP_TM1);
	assign timerIdx[2] = 4'(SMIF_R_GRP_TM2);
	assign timerIdx[3] = 4'(SMIF_R_GRP_TM3);

	always_comb begin
		for (int i = 0; i < SMIF_NUM_REGS; i++) begin
			setVec[i] = 8'h00;
		end
		setVec[SMIF_R_GRP_HALL] = {1'b0, hallSet, 4'h0};
		setVec[SMIF_R_GRP_CAP_ADC] = {captureMatchEvt, captureOverflowEvt, adcLimitEvt,
			adcEndEvt, 4'h0};
		setVec[SMIF_R_GRP_PWM] = {pwmPeriodEvt, pwmDutyEvt, 4'h0};
		for (int t = 0; t < 4; t++) begin
			setVec[timerIdx[t]] = {2'h0, timerMatchEvt[t], timerPeriodEvt[t], 4'h0};
		end
		// a grouped flag is raised by any enabled member event
		mfEvt[0] = |(setVec[SMIF_R_GRP_HALL][6:4] & regs_r[SMIF_R_GRP_HALL][2:0]);
		mfEvt[1] = |(setVec[SMIF_R_GRP_CAP_ADC][7:4] & regs_r[SMIF_R_GRP_CAP_ADC][3:0]);
		mfEvt[2] = |(setVec[SMIF_R_GRP_PWM][7:4] & regs_r[SMIF_R_GRP_PWM][3:0]);
		mfEvt[3] = |(setVec[SMIF_R_GRP_TM2][5:4] & regs_r[SMIF_R_GRP_TM2][1:0]);
		mfEvt[4] = |(setVec[SMIF_R_GRP_TM0][5:4] & regs_r[SMIF_R_GRP_TM0][1:0]);
		mfEvt[5] = |(setVec[SMIF_R_GRP_TM1][5:4] & regs_r[SMIF_R_GRP_TM1][1:0]);
		mfEvt[6] = |(setVec[SMIF_R_GRP_TM3][5:4] & regs_r[SMIF_R_GRP_TM3][1:0]);
		setVec[SMIF_R_PRI_A] = {1'b0, comp0Evt, extSet, mfEvt[0], 4'h0};
		setVec[SMIF_R_PRI_B] = {overcurrentEvt, supplyIrqSet, mfEvt[1], filtSet,
			4'h0};
		setVec[SMIF_R_PRI_C] = {mfEvt[5], mfEvt[4], mfEvt[3], mfEvt[2], 4'h0};
		setVec[SMIF_R_PRI_D] = {timeBaseEvt, mfEvt[6], 1'b0, uartEvt, 4'h0};
	end

	// ****************************************
	// register storage
	// ****************************************
	for (genvar g = 0; g < SMIF_NUM_REGS; g++) begin : gReg
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				regs_r[g] <= SMIF_RST_REG;
			end else if (ce) begin
				if (wrFire && wrDec == {1'b1, 4'(g)} && wStrb0_r) begin
					regs_r[g] <= (wData_r & SMIF_IMPL_MASK[g]) | setVec[g];
				end else begin
					regs_r[g] <= regs_r[g] | setVec[g];
				end
			end
		end
	end

	// ****************************************
	// request and wake outputs
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irqRequest_r <= 1'b0;
			wake_r <= 1'b0;
		end else if (ce) begin
			// the core suspends its program while this stands and its service clears the flag
			irqRequest_r <= regs_r[SMIF_R_PRI_A][SMIF_POS_GLOBAL_EN] & (
				|(regs_r[SMIF_R_PRI_A][6:4] & regs_r[SMIF_R_PRI_A][3:1]) |
				|(regs_r[SMIF_R_PRI_B][7:4] & regs_r[SMIF_R_PRI_B][3:0]) |
				|(regs_r[SMIF_R_PRI_C][7:4] & regs_r[SMIF_R_PRI_C][3:0]) |
				|(regs_r[SMIF_R_PRI_D][7:4] & regs_r[SMIF_R_PRI_D][3:0]));
			// a flag already high cannot become set, which is how software opts out
			wake_r <= idleMode & supplyIrqSet
				& ~regs_r[SMIF_R_PRI_B][SMIF_POS_SUPPLY_IRQ_FLAG];
		end
	end

	assign irqRequest = irqRequest_r;
	assign wakeFromIdle = wake_r;

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	assign s_axi_awready = ce & ~awHeld_r & ~bvalid_r;
	assign s_axi_wready = ce & ~wHeld_r & ~bvalid_r;
	assign wrFire = awHeld_r & wHeld_r & ~bvalid_r;
	assign wrDec = regDecode(awAddr_r);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= 8'h00;
			wStrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= SMIF_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata[7:0];
				wStrb0_r <= s_axi_wstrb[0];
			end
			if (wrFire) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wrDec[4] ? SMIF_RESP_OKAY : SMIF_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	assign s_axi_arready = ce & ~rvalid_r;
	assign rdDec = regDecode(s_axi_araddr);

	always_comb begin
		rdVal = 8'h00;
		if (rdDec[4]) begin
			rdVal = regs_r[rdDec[3:0]];
			if (rdDec[3:0] == 4'(SMIF_R_SUPPLY)) begin
				rdVal[SMIF_POS_LOW_FLAG] = lowFlag;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rvalid_r <= 1'b0;
			rresp_r <= SMIF_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_r <= 1'b1;
				rresp_r <= rdDec[4] ? SMIF_RESP_OKAY : SMIF_RESP_SLVERR;
				rdata_r <= {24'h00_0000, rdVal};
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
endmodule

// [tb/smif_top_asserts.sv]
// port checker of the supply monitor and interrupt flag bank
`timescale 1ns/1ps
module smif_top_asserts(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleepMode,
	input wire logic [2:0] thresholdSelect,
	input wire logic monitorPowerOn,
	input wire logic wakeFromIdle
);
	// ****************************************
	// port relations
	// ****************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	AST_RD_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	AST_SLEEP_OFF: assert property (sleepMode |-> !monitorPowerOn)
		else $error("monitor powered in sleep");
	AST_POWER_CAUSE: assert property (!$stable(monitorPowerOn) |->
		$rose(s_axi_bvalid) || !$stable(sleepMode)) else $error("monitor power changed alone");
	AST_THRESH_CAUSE: assert property (!$stable(thresholdSelect) |-> $rose(s_axi_bvalid))
		else $error("threshold changed without write");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	AST_W_ANSWER: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
	AST_R_ANSWER: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	AST_CE_FREEZE: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while frozen");
	AST_WAKE_PULSE: assert property (wakeFromIdle |=> !wakeFromIdle)
		else $error("wake longer than one cycle");
endmodule
bind smif_top smif_top_asserts u_smif_top_asserts(.clk_sys, .reset, .ce,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .sleepMode, .thresholdSelect, .monitorPowerOn,
	.wakeFromIdle);

// [tb/smif_core_model.sv]
// behavioural core that idles and is woken or serviced
`timescale 1ns/1ps
module smif_core_model(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic goIdle,
	input wire logic irqRequest,
	input wire logic wakeFromIdle,
	output logic idleMode = 1'b0,
	output int wakeCount = 0
);
	// ****************************************
	// idle state
	// ****************************************
	// a pending enabled request keeps the core busy, so it cannot idle
	always @(posedge clk_sys) begin
		if (reset) begin
			idleMode <= 1'b0;
			wakeCount <= 0;
		end else begin
			if (wakeFromIdle) begin
				wakeCount <= wakeCount + 1;
			end
			if (wakeFromIdle || irqRequest) begin
				idleMode <= 1'b0;
			end else if (goIdle) begin
				idleMode <= 1'b1;
			end
		end
	end
endmodule

// [tb/tb_smif_top.sv]
// self-checking bench of the supply monitor and interrupt flag bank
`timescale 1ns/1ps
module tb_smif_top;
	import smif_pkg::*;
	// ****************************************
	// signals and instances
	// ****************************************
	localparam int DLY = 40;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [7:0] EV_ADDR [20] = '{8'h0C, 8'h10, 8'h18, 8'h18, 8'h20, 8'h20, 8'h20,
		8'h20, 8'h24, 8'h24, 8'h24, 8'h24, 8'h2C, 8'h30, 8'h28, 8'h34, 8'h2C, 8'h30, 8'h28, 8'h34};
	localparam int EV_BIT [20] = '{6, 7, 7, 4, 7, 6, 5, 4, 7, 4, 5, 6, 4, 4, 4, 4, 5, 5, 5, 5};
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic supplyLow = 1'b0, sleepMode = 1'b0, extPin = 1'b0, goIdle = 1'b0;
	logic filtPin = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] hallPin = 3'h0, hallCmp = 3'h0, thresholdSelect;
	logic [19:0] evt = 20'h0;
	logic monitorPowerOn, irqRequest, wakeFromIdle, idleMode;
	int wakeCount;
	int num_errors = 0;
	int total_checks = 0;
	always #25 clk_sys = ~clk_sys;
	smif_top #(.IRQ_DELAY_CYC(DLY)) u_smif_top(.clk_sys, .reset, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.supplyBelowThreshold(supplyLow), .sleepMode, .idleMode, .hallPin, .hallCompOut(hallCmp),
		.filteredInputPin(filtPin), .extIrqPin(extPin), .comp0Evt(evt[0]), .overcurrentEvt(evt[1]),
		.timeBaseEvt(evt[2]), .uartEvt(evt[3]), .captureMatchEvt(evt[4]),
		.captureOverflowEvt(evt[5]), .adcLimitEvt(evt[6]), .adcEndEvt(evt[7]),
		.pwmPeriodEvt(evt[8]), .pwmDutyEvt(evt[11:9]), .timerPeriodEvt(evt[15:12]),
		.timerMatchEvt(evt[19:16]), .thresholdSelect, .monitorPowerOn, .irqRequest,
		.wakeFromIdle);
	smif_core_model u_smif_core_model(.clk_sys, .reset, .goIdle, .irqRequest, .wakeFromIdle,
		.idleMode, .wakeCount);
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// both channels offered together; bready comes late so the answer must stand a cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		if (n >= 100) begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata & m);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		if (n >= 100) begin
			num_errors++;
			finish_test();
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		for (int i = 0; i < 14; i++) begin
			rd(8'(4 * i), ALL, 32'h0, SMIF_RESP_OKAY);
		end
		rd(8'h38, ALL, 32'h0, SMIF_RESP_SLVERR);
		wr(8'h38, 32'hFF, SMIF_RESP_SLVERR);
		wr(8'h18, 32'hFF, SMIF_RESP_OKAY);
		rd(8'h18, ALL, 32'hDD, SMIF_RESP_OKAY);
		wr(8'h18, 32'h00, SMIF_RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(8'h18, 32'hFF, SMIF_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(8'h18, ALL, 32'h0, SMIF_RESP_OKAY);
		ce <= 1'b0;
		cyc(2);
		chk("arready", 32'h0, {31'h0, s_axi_arready});
		ce <= 1'b1;
	endtask
	task automatic t_supply_ctrl;
		wr(8'h00, 32'hFF, SMIF_RESP_OKAY);
		rd(8'h00, ALL, 32'h17, SMIF_RESP_OKAY);
		chk("power", 32'h1, {31'h0, monitorPowerOn});
		sleepMode <= 1'b1;
		cyc(1);
		chk("power", 32'h0, {31'h0, monitorPowerOn});
		sleepMode <= 1'b0;
		for (int c = 0; c < 8; c++) begin
			wr(8'h00, 32'h10 | c, SMIF_RESP_OKAY);
			chk("threshold", c, {29'h0, thresholdSelect});
		end
	endtask
	task automatic t_supply_irq;
		wr(8'h0C, 32'h01, SMIF_RESP_OKAY);
		wr(8'h10, 32'h04, SMIF_RESP_OKAY);
		goIdle <= 1'b1;
		cyc(1);
		goIdle <= 1'b0;
		supplyLow <= 1'b1;
		cyc(6);
		rd(8'h00, 32'h20, 32'h20, SMIF_RESP_OKAY);
		rd(8'h10, 32'h40, 32'h00, SMIF_RESP_OKAY);
		cyc(DLY);
		rd(8'h10, 32'h40, 32'h40, SMIF_RESP_OKAY);
		chk("irq", 32'h1, {31'h0, irqRequest});
		chk("wakes", 32'h1, wakeCount);
		wr(8'h10, 32'h04, SMIF_RESP_OKAY);
		rd(8'h10, ALL, 32'h04, SMIF_RESP_OKAY);
		cyc(2);
		chk("irq", 32'h0, {31'h0, irqRequest});
		wr(8'h10, 32'h44, SMIF_RESP_OKAY);
		cyc(2);
		chk("irq", 32'h1, {31'h0, irqRequest});
		wr(8'h0C, 32'h00, SMIF_RESP_OKAY);
		cyc(2);
		chk("irq", 32'h0, {31'h0, irqRequest});
		supplyLow <= 1'b0;
		cyc(6);
		goIdle <= 1'b1;
		cyc(1);
		goIdle <= 1'b0;
		supplyLow <= 1'b1;
		cyc(DLY + 10);
		chk("wakes", 32'h1, wakeCount);
		chk("idle", 32'h1, {31'h0, idleMode});
		supplyLow <= 1'b0;
		wr(8'h00, 32'h00, SMIF_RESP_OKAY);
		wr(8'h10, 32'h00, SMIF_RESP_OKAY);
	endtask
	task automatic t_ext_edge;
		for (int m = 0; m < 4; m++) begin
			wr(8'h08, m, SMIF_RESP_OKAY);
			extPin <= 1'b1;
			cyc(6);
			rd(8'h0C, 32'h20, m[0] ? 32'h20 : 32'h0, SMIF_RESP_OKAY);
			wr(8'h0C, 32'h00, SMIF_RESP_OKAY);
			extPin <= 1'b0;
			cyc(6);
			rd(8'h0C, 32'h20, m[1] ? 32'h20 : 32'h0, SMIF_RESP_OKAY);
			wr(8'h0C, 32'h00, SMIF_RESP_OKAY);
		end
		filtPin <= 1'b1;
		cyc(6);
		rd(8'h10, 32'h10, 32'h10, SMIF_RESP_OKAY);
		wr(8'h10, 32'h00, SMIF_RESP_OKAY);
		filtPin <= 1'b0;
		cyc(6);
		rd(8'h10, 32'h10, 32'h00, SMIF_RESP_OKAY);
	endtask
	task automatic t_hall;
		wr(8'h04, 32'h01, SMIF_RESP_OKAY);
		wr(8'h1C, 32'h01, SMIF_RESP_OKAY);
		hallCmp <= 3'h1;
		cyc(6);
		rd(8'h1C, 32'h70, 32'h00, SMIF_RESP_OKAY);
		hallPin <= 3'h1;
		cyc(6);
		rd(8'h1C, 32'h70, 32'h10, SMIF_RESP_OKAY);
		rd(8'h0C, 32'h10, 32'h10, SMIF_RESP_OKAY);
		wr(8'h04, 32'h41, SMIF_RESP_OKAY);
		wr(8'h1C, 32'h01, SMIF_RESP_OKAY);
		hallCmp <= 3'h0;
		cyc(6);
		hallCmp <= 3'h1;
		cyc(6);
		rd(8'h1C, 32'h70, 32'h10, SMIF_RESP_OKAY);
	endtask
	task automatic t_events;
		for (int i = 0; i < 20; i++) begin
			evt <= 20'h1 << i;
			cyc(1);
			evt <= 20'h0;
			rd(EV_ADDR[i], 32'h1 << EV_BIT[i], 32'h1 << EV_BIT[i], SMIF_RESP_OKAY);
			wr(EV_ADDR[i], 32'h00, SMIF_RESP_OKAY);
		end
		wr(8'h20, 32'h01, SMIF_RESP_OKAY);
		evt <= 20'h80;
		cyc(1);
		evt <= 20'h0;
		rd(8'h10, 32'h20, 32'h20, SMIF_RESP_OKAY);
		wr(8'h10, 32'h00, SMIF_RESP_OKAY);
		wr(8'h20, 32'h00, SMIF_RESP_OKAY);
	endtask
	initial begin
		cyc(4);
		reset <= 1'b0;
		t_regs();
		t_supply_ctrl();
		t_supply_irq();
		t_ext_edge();
		t_hall();
		t_events();
		finish_test();
	end
endmodule
